/* dram_write_leveling.v */
`timescale 1ns/100ps
`include "wrlvl_defines.vh"

module dram_write_leveling (
  input  wire        sys_clk_i,
  input  wire        rst_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  input  wire        link_ck_i,
  input  wire        lower_lane_strobe_i,
  input  wire        upper_lane_strobe_i,
  input  wire        termination_control_pin_i,
  output wire [15:0] dq_o,
  output wire [15:0] dq_oe_o,
  output wire [15:0] dq_undefined_o,
  output reg         strobe_term_on_o,
  output wire        data_term_on_o,
  output wire        output_buffer_off_o,
  output wire        illegal_cmd_o
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_ENTRY = 3'd1;
  localparam [2:0] ST_ARMED = 3'd2;
  localparam [2:0] ST_FEED  = 3'd3;
  localparam [2:0] ST_EXIT  = 3'd4;

  // ----------------------------------------------------------------
  // Delay counts, sized to the counters
  // ----------------------------------------------------------------
  localparam [`CNT_W-1:0] MODE_UPD_CNT   = `MODE_UPDATE_CYCLES;
  localparam [`CNT_W-1:0] STROBE_TRM_CNT = `STROBE_TERM_CYCLES;
  localparam [`CNT_W-1:0] CNT_ZERO       = {`CNT_W{1'b0}};

  reg  [15:0]         mode_reg_one_ff;
  reg  [2:0]          state_ff;
  reg  [2:0]          nxt_state;
  reg  [`CNT_W-1:0]   cnt_ff;
  reg  [`CNT_W-1:0]   nxt_cnt;
  reg  [`CNT_W-1:0]   term_cnt_ff;
  reg                 illegal_ff;
  reg                 ck_s1_ff;
  reg                 ck_s2_ff;
  reg                 odt_s1_ff;
  reg                 odt_s2_ff;
  reg                 term_ready_ff;
  wire [7:0]          lower_dq;
  wire [7:0]          upper_dq;
  wire                wr_en;
  wire                rd_en;
  wire                cmd_wr;
  wire                mode_wr;
  wire                level_bit;
  wire                lane_en;
  wire                rd_setup;
  wire                entry_wr;
  wire                exit_wr;
  wire [31:0]         status_word;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  function addr_ok;
    input [11:0] a;
    begin
      addr_ok = (a == `ADDR_MODE_REG_ONE) || (a == `ADDR_COMMAND) ||
                (a == `ADDR_STATUS) || (a == `ADDR_FEEDBACK);
    end
  endfunction

  // True when a down counter has run out
  function cnt_zero;
    input [`CNT_W-1:0] c;
    begin
      cnt_zero = (c == CNT_ZERO);
    end
  endfunction

  // Command code field of a command register write
  function [2:0] cmd_field;
    input [31:0] d;
    begin
      cmd_field = d[18:16];
    end
  endfunction

  // No wait states: every access ends in its first access cycle
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !addr_ok(paddr_i);
  assign wr_en     = psel_i && penable_i && pwrite_i;
  assign rd_en     = psel_i && penable_i && !pwrite_i;
  // Read data is loaded in the setup cycle so it stands in the access cycle
  assign rd_setup  = psel_i && !penable_i && !pwrite_i;
  assign cmd_wr    = wr_en && (paddr_i == `ADDR_COMMAND);
  assign mode_wr   = cmd_wr && (cmd_field(pwdata_i) == `CMD_MODE_WRITE);
  assign entry_wr  = mode_wr && pwdata_i[`MR1_LEVEL_BIT];
  assign exit_wr   = mode_wr && !pwdata_i[`MR1_LEVEL_BIT];
  assign level_bit = mode_reg_one_ff[`MR1_LEVEL_BIT];

  // ----------------------------------------------------------------
  // Mode register one
  // ----------------------------------------------------------------
  // Loaded only by a mode write command
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      mode_reg_one_ff <= `MR1_RESET;
    end else if (mode_wr) begin
      mode_reg_one_ff <= pwdata_i[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------
  // Status word: sticky flag, termination state, machine state
  assign status_word = {26'h0, illegal_ff, strobe_term_on_o, term_ready_ff, state_ff};

  // Read mux, loaded in the setup cycle of a read
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h00000000;
    end else if (rd_setup) begin
      case (paddr_i)
        `ADDR_MODE_REG_ONE: prdata_o <= {16'h0000, mode_reg_one_ff};
        `ADDR_STATUS:       prdata_o <= status_word;
        `ADDR_FEEDBACK:     prdata_o <= {16'h0000, upper_dq, lower_dq};
        default:            prdata_o <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      ck_s1_ff  <= 1'b0;
      ck_s2_ff  <= 1'b0;
      odt_s1_ff <= 1'b0;
      odt_s2_ff <= 1'b0;
    end else begin
      ck_s1_ff  <= link_ck_i;
      ck_s2_ff  <= ck_s1_ff;
      odt_s1_ff <= termination_control_pin_i;
      odt_s2_ff <= odt_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Leveling state machine
  // ----------------------------------------------------------------
  // Next state and delay counter; entry writes are followed in idle and exit, exit writes in entry, armed and feed
  always @* begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_zero(cnt_ff) ? cnt_ff : cnt_ff - 1'b1;
    case (state_ff)
      ST_IDLE: begin
        if (entry_wr) begin
          nxt_state = ST_ENTRY;
          nxt_cnt   = MODE_UPD_CNT;
        end
      end
      ST_ENTRY: begin
        if (exit_wr) begin
          nxt_state = ST_EXIT;
          nxt_cnt   = MODE_UPD_CNT;
        end else if (cnt_zero(cnt_ff)) begin
          nxt_state = ST_ARMED;
        end
      end
      ST_ARMED, ST_FEED: begin
        if (exit_wr) begin
          nxt_state = ST_EXIT;
          nxt_cnt   = MODE_UPD_CNT;
        end else if (state_ff == ST_ARMED && cnt_zero(term_cnt_ff) &&
                     strobe_term_on_o) begin
          nxt_state = ST_FEED;
        end
      end
      ST_EXIT: begin
        if (entry_wr) begin
          nxt_state = ST_ENTRY;
          nxt_cnt   = MODE_UPD_CNT;
        end else if (cnt_zero(cnt_ff)) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // State and counter registers
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= CNT_ZERO;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Termination handling
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      term_ready_ff    <= 1'b0;
      strobe_term_on_o <= 1'b0;
      term_cnt_ff      <= CNT_ZERO;
    end else begin
      term_ready_ff    <= (state_ff == ST_ARMED) || (state_ff == ST_FEED);
      strobe_term_on_o <= term_ready_ff && odt_s2_ff;
      // Termination must stand a full delay before strobes are used
      if (!(term_ready_ff && odt_s2_ff)) begin
        term_cnt_ff <= STROBE_TRM_CNT;
      end else if (!cnt_zero(term_cnt_ff)) begin
        term_cnt_ff <= term_cnt_ff - 1'b1;
      end
    end
  end

  // Data-line termination only outside leveling; buffer-off bit
  assign data_term_on_o      = !level_bit && odt_s2_ff;
  assign output_buffer_off_o = mode_reg_one_ff[`MR1_QOFF_BIT];

  // ----------------------------------------------------------------
  // Command checking
  // ----------------------------------------------------------------

  // Illegal command flag while leveling, cleared by reading status
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      illegal_ff <= 1'b0;
    end else if (cmd_wr && level_bit && cmd_field(pwdata_i) == `CMD_OTHER) begin
      illegal_ff <= 1'b1;
    end else if (rd_en && paddr_i == `ADDR_STATUS) begin
      illegal_ff <= 1'b0;
    end
  end

  // Sticky flag straight to its pin
  assign illegal_cmd_o = illegal_ff;

  // ----------------------------------------------------------------
  // Feedback lanes
  // ----------------------------------------------------------------
  assign lane_en = (state_ff == ST_FEED);

  // Both lanes take the same synchronised clock, each its own strobe
  // Lower lane
  lane_sampler u_lower (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .strobe_i  (lower_lane_strobe_i),
    .link_ck_i (ck_s2_ff),
    .enable_i  (lane_en),
    .dq_o      (lower_dq)
  );

  // Upper lane
  lane_sampler u_upper (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .strobe_i  (upper_lane_strobe_i),
    .link_ck_i (ck_s2_ff),
    .enable_i  (lane_en),
    .dq_o      (upper_dq)
  );

  // ----------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------
  // Feedback drive; pins flagged undefined around entry and exit
  assign dq_o           = {upper_dq, lower_dq};
  assign dq_oe_o        = (level_bit && !output_buffer_off_o) ? 16'hffff : 16'h0000;
  assign dq_undefined_o = (state_ff == ST_ENTRY || state_ff == ST_ARMED ||
                           state_ff == ST_EXIT) ? 16'hffff : 16'h0000;

endmodule // dram_write_leveling

/* wrlvl_defines.vh */
`ifndef WRLVL_DEFINES_VH
`define WRLVL_DEFINES_VH

// ----------------------------------------------------------------
// Register map (APB byte addresses)
// ----------------------------------------------------------------
`define ADDR_MODE_REG_ONE   12'h000
`define ADDR_COMMAND        12'h004
`define ADDR_STATUS         12'h008
`define ADDR_FEEDBACK       12'h00c

// ----------------------------------------------------------------
// Mode register one field positions and reset value
// ----------------------------------------------------------------
`define MR1_LEVEL_BIT       7
`define MR1_QOFF_BIT        12
`define MR1_RESET           16'h0000

// ----------------------------------------------------------------
// Command codes on the command register
// ----------------------------------------------------------------
`define CMD_NOP             3'h0
`define CMD_DESELECT        3'h1
`define CMD_MODE_WRITE      3'h2
`define CMD_OTHER           3'h3

// ----------------------------------------------------------------
// Timing (link clock cycles counted in system clocks)
// ----------------------------------------------------------------
`define MODE_UPDATE_DELAY_CK  12
`define MODE_COMMAND_GAP_CK   4
`define STROBE_TERM_DELAY_CK  25
`define LINK_CK_NS            160
`define SYS_CK_NS             5
`define MODE_UPDATE_CYCLES    (`MODE_UPDATE_DELAY_CK * `LINK_CK_NS / `SYS_CK_NS)
`define STROBE_TERM_CYCLES    (`STROBE_TERM_DELAY_CK * `LINK_CK_NS / `SYS_CK_NS)
`define CNT_W                 12

`endif

/* lane_sampler.v */
`timescale 1ns/100ps

// ----------------------------------------------------------------
// One byte lane: samples clock level on rising strobe edge
// ----------------------------------------------------------------
module lane_sampler (
  input  wire       sys_clk_i,
  input  wire       rst_i,
  input  wire       strobe_i,
  input  wire       link_ck_i,
  input  wire       enable_i,
  output reg  [7:0] dq_o
);

  reg strobe_s1_ff;
  reg strobe_s2_ff;
  reg strobe_d_ff;

  // Two stage synchroniser for the strobe
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      strobe_s1_ff <= 1'b0;
      strobe_s2_ff <= 1'b0;
      strobe_d_ff  <= 1'b0;
    end else begin
      strobe_s1_ff <= strobe_i;
      strobe_s2_ff <= strobe_s1_ff;
      strobe_d_ff  <= strobe_s2_ff;
    end
  end

  // Capture clock level on rising strobe, hold until next
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      dq_o <= 8'h00;
    end else if (!enable_i) begin
      dq_o <= 8'h00;
    end else if (strobe_s2_ff && !strobe_d_ff) begin
      dq_o <= {8{link_ck_i}};
    end
  end

endmodule // lane_sampler

/* dram_write_leveling_assertions.sv */
`timescale 1ns/100ps
module wl_chk (
  input wire        sys_clk_i,
  input wire        rst_i,
  input wire        lower_lane_strobe_i,
  input wire        upper_lane_strobe_i,
  input wire        termination_control_pin_i,
  input wire [15:0] dq_o,
  input wire [15:0] dq_oe_o,
  input wire [15:0] dq_undefined_o,
  input wire        strobe_term_on_o,
  input wire        data_term_on_o,
  input wire        output_buffer_off_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // ------
  // Strobe age
  // ------
  reg [1:0] stb_ff;
  reg [3:0] lo_age_ff;
  reg [3:0] up_age_ff;
  // Cycles since each rising strobe, saturating
  always @(posedge sys_clk_i) begin
    stb_ff    <= {upper_lane_strobe_i, lower_lane_strobe_i};
    if (rst_i) begin
      lo_age_ff <= 4'hf;
      up_age_ff <= 4'hf;
    end else begin
      lo_age_ff <= (lower_lane_strobe_i & ~stb_ff[0]) ? 4'h0 : lo_age_ff + {3'h0, ~&lo_age_ff};
      up_age_ff <= (upper_lane_strobe_i & ~stb_ff[1]) ? 4'h0 : up_age_ff + {3'h0, ~&up_age_ff};
    end
  end
  // ------
  // Properties
  // ------
  a_data_term_off: assert property (dq_oe_o != 16'h0 |-> !data_term_on_o)
    else $error("data termination on while leveling");
  a_term_follow: assert property ($rose(strobe_term_on_o) |-> $past(termination_control_pin_i, 2))
    else $error("strobe termination without pin");
  a_term_drop: assert property ($fell(termination_control_pin_i) |-> ##[1:6] !strobe_term_on_o)
    else $error("strobe termination stuck on");
  a_lane_uniform: assert property ((dq_o[7:0] == 8'h0 || dq_o[7:0] == 8'hff)
    && (dq_o[15:8] == 8'h0 || dq_o[15:8] == 8'hff))
    else $error("feedback bits differ in a lane");
  a_lower_hold: assert property (dq_oe_o[0] && $past(dq_oe_o[0]) && $changed(dq_o[7:0])
    |-> lo_age_ff < 4'hc)
    else $error("lower feedback changed without strobe");
  a_upper_hold: assert property (dq_oe_o[0] && $past(dq_oe_o[0]) && $changed(dq_o[15:8])
    |-> up_age_ff < 4'hc)
    else $error("upper feedback changed without strobe");
  a_buf_off: assert property (output_buffer_off_o |-> dq_oe_o == 16'h0)
    else $error("drivers on with buffer off");
  a_entry_undef: assert property ($rose(dq_oe_o[0]) |-> ##[0:2] dq_undefined_o == 16'hffff)
    else $error("entry not flagged undefined");
  a_oe_whole: assert property (dq_oe_o == 16'h0 || dq_oe_o == 16'hffff)
    else $error("partial output enable");
  cover property ($rose(strobe_term_on_o));
  cover property ($rose(dq_o[0]));
  cover property ($rose(dq_o[8]));
endmodule // wl_chk

bind dram_write_leveling wl_chk u_chk (.sys_clk_i, .rst_i, .lower_lane_strobe_i,
  .upper_lane_strobe_i, .termination_control_pin_i, .dq_o, .dq_oe_o, .dq_undefined_o,
  .strobe_term_on_o, .data_term_on_o, .output_buffer_off_o);

/* wl_ctrl_model.sv */
`timescale 1ns/100ps
module wl_ctrl_model (
  input  wire [15:0] dq_i,
  output reg         link_ck_o,
  output reg         lower_lane_strobe_o,
  output reg         upper_lane_strobe_o,
  output reg         termination_control_pin_o
);
  // Idle levels, strobes held low
  initial begin
    link_ck_o                 = 1'b0;
    lower_lane_strobe_o       = 1'b0;
    upper_lane_strobe_o       = 1'b0;
    termination_control_pin_o = 1'b0;
  end
  // Free-running device clock
  always #80 link_ck_o = ~link_ck_o;
  // Termination pin level
  task termination_control_pin(input bit on);
    termination_control_pin_o <= on;
  endtask
  // One delayed strobe pulse per lane, then feedback sampled
  task pulse(input int dl, input int du, output logic [15:0] fb);
    fork
      begin @(posedge link_ck_o); #(dl) lower_lane_strobe_o = 1'b1; #40 lower_lane_strobe_o = 1'b0; end
      begin @(posedge link_ck_o); #(du) upper_lane_strobe_o = 1'b1; #40 upper_lane_strobe_o = 1'b0; end
    join
    #60 fb = dq_i;
  endtask
endmodule // wl_ctrl_model

/* tb_dram_write_leveling.sv */
`timescale 1ns/100ps
`include "wrlvl_defines.vh"
module tb_dram_write_leveling;
  reg sys_clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  reg  [11:0] paddr_i  = 12'h0;
  reg  [31:0] pwdata_i = 32'h0;
  wire [31:0] prdata_o;
  wire [15:0] dq_o, dq_oe_o, dq_undefined_o;
  wire pready_o, pslverr_o, link_ck_i, lower_lane_strobe_i, upper_lane_strobe_i;
  wire termination_control_pin_i, strobe_term_on_o, data_term_on_o;
  wire output_buffer_off_o, illegal_cmd_o;
  integer bad_count = 0, n_tests = 0, seed = 32'hdf1a, i, d;
  reg [31:0] rd;
  reg        err;
  logic [15:0] fb;

  dram_write_leveling dut_u (.sys_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .link_ck_i, .lower_lane_strobe_i,
    .upper_lane_strobe_i, .termination_control_pin_i, .dq_o, .dq_oe_o, .dq_undefined_o,
    .strobe_term_on_o, .data_term_on_o, .output_buffer_off_o, .illegal_cmd_o);
  wl_ctrl_model ctl_u (.dq_i(dq_o), .link_ck_o(link_ck_i), .lower_lane_strobe_o(lower_lane_strobe_i),
    .upper_lane_strobe_o(upper_lane_strobe_i), .termination_control_pin_o(termination_control_pin_i));

  // System clock
  always #2.5 sys_clk_i = ~sys_clk_i;
  // ------
  // Tasks
  // ------
  task cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task chk(input string nm, input [31:0] ex, input [31:0] got);
    n_tests++;
    if (got !== ex) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task apb(input bit w, input [11:0] a, input [31:0] wd);
    int k;
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= wd;
    @(posedge sys_clk_i) penable_i <= 1'b1;
    k = 0;
    do begin @(posedge sys_clk_i); k++; end while (pready_o !== 1'b1 && k < 50);
    if (pready_o !== 1'b1) chk("pready", 1, 0);
    // Answer taken at the completing edge, then the request is released
    rd  = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task mw(input [15:0] mr);
    apb(1, `ADDR_COMMAND, {13'h0, `CMD_MODE_WRITE, mr});
  endtask
  function bit lvl(input int t);
    lvl = (t % 160) < 80;
  endfunction
  task conclude;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000 bad_count++;
    conclude;
  end
  // ------
  // Main sequence
  // ------
  initial begin
    cyc(8); rst_i <= 1'b0; cyc(1);
    apb(0, `ADDR_MODE_REG_ONE, 0); chk("mode reset", 0, rd);
    apb(0, 12'h010, 0); chk("unmapped err", 1, 32'(err)); chk("unmapped rd", 0, rd);
    mw(16'h0080); cyc(3);
    chk("undef entry", 16'hffff, 32'(dq_undefined_o));
    chk("oe entry", 16'hffff, 32'(dq_oe_o));
    apb(0, `ADDR_MODE_REG_ONE, 0); chk("mode rd", 16'h0080, rd);
    cyc(400); ctl_u.termination_control_pin(1); cyc(10);
    chk("data term", 0, 32'(data_term_on_o));
    cyc(810); chk("strobe term", 1, 32'(strobe_term_on_o));
    for (i = 0; i < 8; i++) begin
      d = 15 + ($random(seed) & 31) + (i[0] ? 80 : 0);
      ctl_u.pulse(d, d + 80, fb);
      chk("lower lane", {8{lvl(d)}}, 32'(fb[7:0]));
      chk("upper lane", {8{lvl(d + 80)}}, 32'(fb[15:8]));
      chk("undef feed", 0, 32'(dq_undefined_o));
    end
    for (i = 0; i < 4; i++) begin
      if (i == 2) continue;
      apb(1, `ADDR_COMMAND, {13'h0, i[2:0], 16'h0});
      chk("illegal pin", 32'(i == 3), 32'(illegal_cmd_o));
      apb(0, `ADDR_STATUS, 0); chk("illegal", 32'(i == 3), 32'(rd[5]));
    end
    apb(0, `ADDR_STATUS, 0); chk("illegal clr", 0, 32'(rd[5]));
    chk("illegal pin clr", 0, 32'(illegal_cmd_o));
    ctl_u.termination_control_pin(0); cyc(10);
    chk("term off", 0, 32'(strobe_term_on_o));
    mw(16'h0000); cyc(3);
    chk("undef exit", 16'hffff, 32'(dq_undefined_o));
    cyc(400);
    chk("undef idle", 0, 32'(dq_undefined_o));
    chk("oe idle", 0, 32'(dq_oe_o));
    ctl_u.termination_control_pin(1); cyc(5);
    chk("data term idle", 1, 32'(data_term_on_o));
    chk("strobe term idle", 0, 32'(strobe_term_on_o));
    ctl_u.termination_control_pin(0); cyc(5);
    mw(16'h1080); cyc(3);
    chk("buf off", 1, 32'(output_buffer_off_o));
    chk("oe off", 0, 32'(dq_oe_o));
    mw(16'h0000); cyc(400);
    chk("undef after", 0, 32'(dq_undefined_o));
    conclude;
  end
endmodule // tb_dram_write_leveling
